// file: hdl/fdhi_pkg.sv
// constants, offsets and timing counts for the flexible disk drive host interface
package fdhi_pkg;
	// clock rate
	localparam int CLK_MHZ = 250;
	// times in microseconds, index period in milliseconds, with their cycle counts
	localparam int T_SEEK_US = 21000;
	localparam int SEEK_CYC = T_SEEK_US * CLK_MHZ;
	localparam int T_T00_US = 5800;
	localparam int T00_CYC = T_T00_US * CLK_MHZ;
	localparam int T_WG_US = 1000;
	localparam int WG_CYC = T_WG_US * CLK_MHZ;
	localparam int T_SIDE_US = 100;
	localparam int SIDE_CYC = T_SIDE_US * CLK_MHZ;
	localparam int T_IDX_MS = 200;
	localparam int IDX_NOM_CYC = T_IDX_MS * 1000 * CLK_MHZ;
	localparam int IDX_TOL_PCT = 6;
	localparam int HALF_PCT = 50;
	localparam int IDX_LO_CYC = IDX_NOM_CYC - (IDX_NOM_CYC / 100) * IDX_TOL_PCT;
	localparam int IDX_HI_CYC = IDX_NOM_CYC + (IDX_NOM_CYC / 100) * IDX_TOL_PCT;
	localparam int IDX_SLOW_CYC = (IDX_NOM_CYC / HALF_PCT) * 100;
	// geometry and counts
	localparam int NUM_UNITS = 4;
	localparam int NUM_TRACKS = 40;
	localparam int TRK_W = 7;
	localparam logic [1:0] READY_GOOD = 2'h2;
	localparam int CNT_W = 32;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IDXPER = 8'h08;
	localparam logic [2:0] CTRL_RST = 3'h1;
	localparam int CTRL_READY_BIT = 0;
	localparam int CTRL_IDX_BIT = 1;
	localparam int CTRL_RD_BIT = 2;
	localparam int ST_TRK_LSB = 8;
	// output line indices
	localparam int OUT_INDEX = 0;
	localparam int OUT_TRK0 = 1;
	localparam int OUT_WPROT = 2;
	localparam int OUT_RDATA = 3;
	localparam int OUT_READY = 4;
	localparam int NOUT = 5;
	// synchronised input indices
	localparam int IN_STEP = 0;
	localparam int IN_DIR = 1;
	localparam int IN_WG = 2;
	localparam int IN_WD = 3;
	localparam int IN_SIDE = 4;
	localparam int IN_MOTOR = 5;
	localparam int IN_USE = 6;
	localparam int IN_IDXH = 7;
	localparam int IN_T0 = 8;
	localparam int IN_WP = 9;
	localparam int IN_DISK = 10;
	localparam int IN_RDP = 11;
	localparam int IN_IUJ = 12;
	localparam int IN_SEL = 13;
	localparam int IN_JMP = 17;
	localparam int NIN = 21;
	// timer slots
	localparam int TM_SEEK = 0;
	localparam int TM_T00 = 1;
	localparam int TM_WG = 2;
	localparam int TM_SIDE = 3;
	localparam int NTM = 4;
endpackage : fdhi_pkg

// file: hdl/fdhi_sync.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module fdhi_sync #(
	parameter int W = 1
) (
	input wire logic mclk_i, // clock
	input wire logic rst_i, // synchronous reset
	input wire logic [W-1:0] d_i, // asynchronous inputs
	output logic [W-1:0] q_o, // synchronised level
	output logic [W-1:0] rise_o, // one-cycle rise pulse
	output logic [W-1:0] fall_o // one-cycle fall pulse
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;
	// first flop feeds only the second; every bit resets high, the idle level of the active-low host lines
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta <= '1;
			q_o <= '1;
			prev <= '1;
		end else begin
			meta <= d_i;
			q_o <= meta;
			prev <= q_o;
		end
	end
	assign rise_o = q_o & ~prev;
	assign fall_o = ~q_o & prev;
endmodule : fdhi_sync
`default_nettype wire

// file: hdl/fdhi_timer.sv
// reloadable down-counter that reports busy until it expires
`timescale 1ns/1ps
`default_nettype none
module fdhi_timer (
	input wire logic mclk_i, // clock
	input wire logic rst_i, // synchronous reset
	fdhi_tmr_if.timer t // start, load and busy
);
	logic [31:0] cnt;
	// a start while running restarts the interval
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt <= 32'h0;
		end else if (t.start) begin
			cnt <= t.load;
		end else if (cnt != 32'h0) begin
			cnt <= cnt - 32'h1;
		end
	end
	assign t.busy = (cnt != 32'h0);
endmodule : fdhi_timer
`default_nettype wire

// file: hdl/fdhi_tmr_if.sv
// interface between the control logic and one interval timer
`timescale 1ns/1ps
`default_nettype none
interface fdhi_tmr_if;
	logic start;
	logic [31:0] load;
	logic busy;
	modport user (output start, output load, input busy);
	modport timer (input start, input load, output busy);
endinterface : fdhi_tmr_if
`default_nettype wire

// file: hdl/fdhi_top.sv
// drive-side logic of the 34-line daisy-chain flexible disk interface
// Functional notes
// - up to four drives share one cable
// - all interface lines are active low
// - answer only the select matching the jumper
// - gate lines by select, except motor, activity
// - selection takes effect within half a microsecond
// - motor request starts spindle toward rated speed
// - direction high outward, low inward, on step
// - one track per accepted wide step pulse
// - move on trailing edge, settle within limit
// - ignore steps while writing is in progress
// - ignore outward steps at outermost track
// - write mode needs gate, select, no protect
// - record flux on write pulse leading edge
// - drop write pulses unless gated and unprotected
// - side line high side zero, low one
// - read data blanked after side change
// - activity input used only with its jumper
// - outermost flag valid after delay from step
// - pulse index line on each hole; here only while ready or with the control index bit set
// - one index pulse per revolution, soft media
// - ready after two good half-speed index intervals
// - ready cleared promptly when motor request drops
`timescale 1ns/1ps
`default_nettype none
module fdhi_top
	import fdhi_pkg::*;
#(
	parameter int SEEK_CYC_P = SEEK_CYC,
	parameter int T00_CYC_P = T00_CYC,
	parameter int WG_CYC_P = WG_CYC,
	parameter int SIDE_CYC_P = SIDE_CYC,
	parameter int IDX_LO_P = IDX_LO_CYC,
	parameter int IDX_HI_P = IDX_HI_CYC,
	parameter int IDX_SLOW_P = IDX_SLOW_CYC
) (
	input wire logic mclk_i, // 250 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic [7:0] paddr_i, // apb address
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	input wire logic [3:0] drive_sel_n_i, // unit selection lines
	input wire logic motor_on_n_i, // spindle-run request
	input wire logic direction_n_i, // seek direction, high is outward
	input wire logic step_n_i, // step pulse
	input wire logic write_data_n_i, // write data pulses
	input wire logic write_gate_n_i, // write enable
	input wire logic side_one_n_i, // side select, low is side one
	input wire logic in_use_n_i, // host-activity input
	input wire logic [3:0] unit_address_jumpers_i, // fitted address jumper
	input wire logic activity_input_jumper_i, // enables the activity input
	input wire logic index_hole_i, // index or sector hole seen
	input wire logic track0_sensor_i, // head on outermost track
	input wire logic write_protect_sensor_i, // notch masked
	input wire logic disk_present_i, // disk installed
	input wire logic read_pulse_i, // flux pulse from read channel
	output logic [4:0] line_n_o, // output line levels, active low
	output logic [4:0] line_oe_o, // output line drive enables
	output logic spindle_run_o, // spindle motor enable
	output logic stepper_pulse_o, // one-track move request
	output logic stepper_inward_o, // move toward the centre
	output logic head_side_one_o, // head select
	output logic write_enable_o, // write current enable
	output logic write_flux_o, // flux transition to record
	output logic activity_o // host activity seen
);
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s;
	logic [NIN-1:0] s_rise;
	logic [NIN-1:0] s_fall;
	logic [2:0] ctrl;
	logic [TRK_W-1:0] track;
	logic [CNT_W-1:0] idx_cnt;
	logic [CNT_W-1:0] idx_period;
	logic [1:0] good_cnt;
	logic ready;
	logic write_mode_q;
	fdhi_tmr_if tif[NTM] ();
	localparam int TM_LOAD [NTM] = '{SEEK_CYC_P, T00_CYC_P, WG_CYC_P, SIDE_CYC_P};

	// every drive-side pin passes two flops before use
	assign raw = {unit_address_jumpers_i, drive_sel_n_i, activity_input_jumper_i,
		read_pulse_i, disk_present_i, write_protect_sensor_i, track0_sensor_i,
		index_hole_i, in_use_n_i, motor_on_n_i, side_one_n_i, write_data_n_i,
		write_gate_n_i, direction_n_i, step_n_i};
	fdhi_sync #(.W(NIN)) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.d_i(raw),
		.q_o(s),
		.rise_o(s_rise),
		.fall_o(s_fall)
	);

	// interval timers for seek, outermost flag, write recovery and side change
	genvar gi;
	generate
		for (gi = 0; gi < NTM; gi++) begin : g_tmr
			assign tif[gi].load = 32'(TM_LOAD[gi]);
			fdhi_timer u_tmr (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.t(tif[gi])
			);
		end
	endgenerate

	// unit selection: line low and its jumper fitted
	wire [3:0] sel_true = ~s[IN_SEL +: NUM_UNITS];
	wire selected = |(sel_true & s[IN_JMP +: NUM_UNITS]);

	// host line decode, converted to true levels; write gate, step and side gated by selection
	wire motor_true = ~s[IN_MOTOR];
	wire dir_out = s[IN_DIR];
	wire wg_true = selected & ~s[IN_WG];
	wire wprot = s[IN_WP];
	wire trk0_sensor = s[IN_T0];
	wire disk_in = s[IN_DISK];
	wire write_mode = wg_true & ~wprot;
	wire step_trail = selected & s_rise[IN_STEP];
	wire step_block_wr = write_mode;
	wire step_block_t0 = trk0_sensor & dir_out;
	wire step_accept = step_trail & ~step_block_wr & ~step_block_t0;
	wire wd_lead = s_fall[IN_WD];
	wire flux_ok = write_mode & wd_lead;
	wire side_change = selected & (s_rise[IN_SIDE] | s_fall[IN_SIDE]);
	wire wg_end = write_mode_q & ~write_mode;

	// timer starts
	assign tif[TM_SEEK].start = step_accept;
	assign tif[TM_T00].start = step_accept;
	assign tif[TM_WG].start = wg_end;
	assign tif[TM_SIDE].start = side_change;
	wire seek_busy = tif[TM_SEEK].busy;
	wire t00_blank = tif[TM_T00].busy;
	wire wg_recover = tif[TM_WG].busy;
	wire side_settle = tif[TM_SIDE].busy;

	// index interval checks against half speed and the tolerance band
	wire idx_edge = s_rise[IN_IDXH];
	wire idx_fast_enough = (idx_cnt < CNT_W'(IDX_SLOW_P));
	wire idx_in_band = (idx_cnt >= CNT_W'(IDX_LO_P)) & (idx_cnt <= CNT_W'(IDX_HI_P));
	wire spin_ok = motor_true & disk_in;

	// line truth values before selection gating
	wire idx_true = s[IN_IDXH] & (ready | ctrl[CTRL_IDX_BIT]);
	wire t0_true = trk0_sensor & ~t00_blank;
	wire rd_true = s[IN_RDP] & (ready | ctrl[CTRL_RD_BIT]) & ~write_mode
		& ~wg_recover & ~side_settle;
	wire rdy_true = ready & ctrl[CTRL_READY_BIT];
	wire [NOUT-1:0] line_true = {rdy_true, rd_true, wprot, t0_true, idx_true};
	wire [NOUT-1:0] line_en = {ctrl[CTRL_READY_BIT], {(NOUT - 1){1'b1}}};

	// apb decode
	wire apb_setup = psel_i & ~penable_i;
	wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
	wire hit_ctrl = (paddr_i == REG_CTRL);
	wire hit_status = (paddr_i == REG_STATUS);
	wire hit_idxper = (paddr_i == REG_IDXPER);
	wire hit_any = hit_ctrl | hit_status | hit_idxper;
	wire [31:0] status_word = {17'h0, track, activity_o, ~s[IN_SIDE], wprot, t0_true,
		seek_busy, write_mode, ready, selected};
	wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl} :
		hit_status ? status_word :
		hit_idxper ? idx_period : 32'h0;

	// apb slave: answers in the first access cycle
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= apb_setup;
			prdata_o <= apb_setup ? rd_mux : 32'h0;
			pslverr_o <= apb_setup & ~hit_any;
		end
	end

	// control register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RST;
		end else if (apb_wr & hit_ctrl) begin
			ctrl <= pwdata_i[2:0];
		end
	end

	// head position: one track per accepted step, zeroed when the sensor comes on
	// a level test here would undo the first inward step while the sensor still lags
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			track <= '0;
		end else if (s_rise[IN_T0] & ~step_accept) begin
			track <= '0;
		end else if (step_accept & dir_out & (track != '0)) begin
			track <= track - TRK_W'(1);
		end else if (step_accept & ~dir_out & (track != TRK_W'(NUM_TRACKS - 1))) begin
			track <= track + TRK_W'(1);
		end
	end

	// stepper drive on the trailing edge of each accepted step
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			stepper_pulse_o <= 1'b0;
			stepper_inward_o <= 1'b0;
		end else begin
			stepper_pulse_o <= step_accept;
			if (step_accept) begin
				stepper_inward_o <= ~dir_out;
			end
		end
	end

	// index interval counter, saturating while no hole arrives
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			idx_cnt <= '0;
			idx_period <= '0;
		end else if (idx_edge) begin
			idx_period <= idx_cnt;
			idx_cnt <= CNT_W'(1); // the edge cycle counts, so the period is whole
		end else if (idx_cnt != '1) begin
			idx_cnt <= idx_cnt + CNT_W'(1);
		end
	end

	// ready detection; drops at once when the motor request ends
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			good_cnt <= 2'h0;
			ready <= 1'b0;
		end else if (~spin_ok) begin
			good_cnt <= 2'h0;
			ready <= 1'b0;
		end else if (~idx_fast_enough) begin
			good_cnt <= 2'h0;
			ready <= 1'b0;
		end else if (idx_edge) begin
			if (good_cnt != READY_GOOD) begin
				good_cnt <= good_cnt + 2'h1;
			end
			ready <= (good_cnt != 2'h0) & idx_in_band;
		end
	end

	// spindle, side and write path to the mechanism
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			spindle_run_o <= 1'b0;
			head_side_one_o <= 1'b0;
			write_enable_o <= 1'b0;
			write_flux_o <= 1'b0;
			write_mode_q <= 1'b0;
			activity_o <= 1'b0;
		end else begin
			spindle_run_o <= motor_true;
			if (selected) begin
				head_side_one_o <= ~s[IN_SIDE];
			end
			write_enable_o <= write_mode;
			write_flux_o <= flux_ok;
			write_mode_q <= write_mode;
			activity_o <= s[IN_IUJ] & ~s[IN_USE];
		end
	end

	// open-collector outputs, released while another unit is selected
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			line_n_o <= '1;
			line_oe_o <= '0;
		end else begin
			line_n_o <= ~(line_true & line_en & {NOUT{selected}});
			line_oe_o <= line_true & line_en & {NOUT{selected}};
		end
	end
endmodule : fdhi_top
`default_nettype wire

// file: verif/fdhi_host_model.sv
// host controller model driving the daisy-chain input lines
`timescale 1ns/1ps
`default_nettype none
module fdhi_host_model #(
	parameter int GAP = 250 // step spacing, scaled down
) (
	input wire logic mclk_i, // clock
	output logic [3:0] sel_n_o, // unit selection
	output logic motor_n_o, // spindle request
	output logic dir_n_o, // direction, high outward
	output logic step_n_o, // step pulse
	output logic wd_n_o, // write data pulses
	output logic wg_n_o, // write gate
	output logic side_n_o // side select
);
	// every line idles false, which is high
	initial begin
		{sel_n_o, motor_n_o, dir_n_o, step_n_o, wd_n_o, wg_n_o, side_n_o} = 10'h3ff;
	end
	// level lines, then wait out select and side settling
	task automatic lv(input logic [3:0] s, input logic m, input logic sd);
		sel_n_o <= s;
		motor_n_o <= m;
		side_n_o <= sd;
		repeat (20) @(posedge mclk_i);
	endtask : lv
	// one step wider than the minimum, then the spacing gap
	task automatic step(input logic out);
		dir_n_o <= out;
		repeat (2) @(posedge mclk_i);
		step_n_o <= 1'b0;
		repeat (201) @(posedge mclk_i);
		step_n_o <= 1'b1;
		repeat (GAP) @(posedge mclk_i);
	endtask : step
	// gated burst of n flux pulses; st sends a stray step mid-write
	task automatic write(input int n, input logic st);
		wg_n_o <= 1'b0;
		repeat (8) @(posedge mclk_i);
		if (st)
			step(1'b0);
		repeat (n) begin
			wd_n_o <= 1'b0;
			repeat (30) @(posedge mclk_i);
			wd_n_o <= 1'b1;
			repeat (30) @(posedge mclk_i);
		end
		wg_n_o <= 1'b1;
		repeat (40) @(posedge mclk_i);
	endtask : write
endmodule : fdhi_host_model
`default_nettype wire

// file: verif/fdhi_top_monitor.sv
// concurrent checks on the drive-side ports
`timescale 1ns/1ps
`default_nettype none
module fdhi_top_monitor (
	input wire logic mclk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [3:0] drive_sel_n_i, // selection lines
	input wire logic [3:0] unit_address_jumpers_i, // address jumper
	input wire logic motor_on_n_i, // spindle request
	input wire logic direction_n_i, // direction
	input wire logic step_n_i, // step
	input wire logic write_gate_n_i, // write gate
	input wire logic side_one_n_i, // side
	input wire logic in_use_n_i, // activity
	input wire logic activity_input_jumper_i, // activity jumper
	input wire logic track0_sensor_i, // outer track sensor
	input wire logic write_protect_sensor_i, // protect sensor
	input wire logic [4:0] line_n_o, // line levels
	input wire logic [4:0] line_oe_o, // line enables
	input wire logic spindle_run_o, // motor
	input wire logic stepper_pulse_o, // move
	input wire logic stepper_inward_o, // move inward
	input wire logic head_side_one_o, // head
	input wire logic write_enable_o, // write mode
	input wire logic write_flux_o, // flux
	input wire logic activity_o // activity
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// own selection and write-mode condition at the pins
	wire logic sel = |(~drive_sel_n_i & unit_address_jumpers_i);
	wire logic wr_ok = sel && !write_gate_n_i && !write_protect_sensor_i;
	sequence sel_lost;
		(!sel)[*5];
	endsequence
	sequence step_released;
		!$past(step_n_i, 6) && $past(step_n_i, 2);
	endsequence
	unsel_release_a: assert property (sel_lost |=> line_oe_o == 5'h0 && line_n_o == 5'h1f)
		else $error("lines driven while unselected");
	line_level_a: assert property ((sel && $stable(write_protect_sensor_i))[*5] |=>
		line_oe_o[2] == $past(write_protect_sensor_i) && line_n_o[2] == !$past(write_protect_sensor_i))
		else $error("protect line wrong");
	step_origin_a: assert property (stepper_pulse_o |-> step_released ##1 !stepper_pulse_o)
		else $error("move without a released step");
	step_blocked_a: assert property (stepper_pulse_o |-> !$past(write_enable_o, 4) &&
		!($past(track0_sensor_i, 4) && $past(direction_n_i, 4)))
		else $error("step not ignored");
	step_dir_a: assert property (stepper_pulse_o |-> stepper_inward_o == !$past(direction_n_i, 4))
		else $error("wrong move direction");
	write_mode_a: assert property ($stable(wr_ok)[*5] |=> write_enable_o == $past(wr_ok))
		else $error("write mode wrong");
	flux_gate_a: assert property (write_flux_o |-> $past(write_enable_o) ##1 !write_flux_o)
		else $error("flux outside write mode");
	side_head_a: assert property ((sel && $stable(side_one_n_i))[*5] |=>
		head_side_one_o == !$past(side_one_n_i))
		else $error("wrong head selected");
	spindle_run_a: assert property ($stable(motor_on_n_i)[*5] |=>
		spindle_run_o == !$past(motor_on_n_i))
		else $error("spindle does not follow request");
	activity_a: assert property (($stable(in_use_n_i) && $stable(activity_input_jumper_i))[*5] |=>
		activity_o == ($past(activity_input_jumper_i) && !$past(in_use_n_i)))
		else $error("activity output wrong");
endmodule : fdhi_top_monitor
bind fdhi_top fdhi_top_monitor u_mon (.mclk_i, .rst_i, .drive_sel_n_i, .unit_address_jumpers_i,
	.motor_on_n_i, .direction_n_i, .step_n_i, .write_gate_n_i, .side_one_n_i, .in_use_n_i,
	.activity_input_jumper_i, .track0_sensor_i, .write_protect_sensor_i, .line_n_o, .line_oe_o,
	.spindle_run_o, .stepper_pulse_o, .stepper_inward_o, .head_side_one_o, .write_enable_o,
	.write_flux_o, .activity_o);
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the drive-side disk interface
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fdhi_pkg::*;
;
	logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
	logic pready_o, pslverr_o, rerr, d, iw_q = 1'b0, lin = 1'b0;
	logic in_use_n_i = 1'b1, activity_input_jumper_i = 1'b0, index_hole_i = 1'b0;
	logic track0_sensor_i = 1'b1, write_protect_sensor_i = 1'b0, disk_present_i = 1'b0;
	logic read_pulse_i = 1'b0;
	logic [3:0] unit_address_jumpers_i, me;
	wire logic [3:0] drive_sel_n_i;
	wire logic motor_on_n_i, direction_n_i, step_n_i, write_data_n_i, write_gate_n_i, side_one_n_i;
	logic [4:0] line_n_o, line_oe_o;
	logic spindle_run_o, stepper_pulse_o, stepper_inward_o, head_side_one_o;
	logic write_enable_o, write_flux_o, activity_o;
	int num_errors = 0, cmp_count = 0, npulse = 0, nflux = 0, nidx = 0, icnt = 0, trk = 0;
	int n0, n1, ju;
	always #2 mclk_i = ~mclk_i;
	fdhi_top #(.SEEK_CYC_P(200), .T00_CYC_P(60), .WG_CYC_P(20), .SIDE_CYC_P(10),
		.IDX_LO_P(940), .IDX_HI_P(1060), .IDX_SLOW_P(2000)) u_dut (.mclk_i, .rst_i, .paddr_i,
		.psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.drive_sel_n_i, .motor_on_n_i, .direction_n_i, .step_n_i, .write_data_n_i,
		.write_gate_n_i, .side_one_n_i, .in_use_n_i, .unit_address_jumpers_i,
		.activity_input_jumper_i, .index_hole_i, .track0_sensor_i, .write_protect_sensor_i,
		.disk_present_i, .read_pulse_i, .line_n_o, .line_oe_o, .spindle_run_o,
		.stepper_pulse_o, .stepper_inward_o, .head_side_one_o, .write_enable_o,
		.write_flux_o, .activity_o);
	fdhi_host_model u_host (.mclk_i, .sel_n_o(drive_sel_n_i), .motor_n_o(motor_on_n_i),
		.dir_n_o(direction_n_i), .step_n_o(step_n_i), .wd_n_o(write_data_n_i),
		.wg_n_o(write_gate_n_i), .side_n_o(side_one_n_i));
	// index hole every 1000 cycles, read flux, counters of design pulses
	always @(posedge mclk_i) begin
		icnt <= (icnt == 999) ? 0 : icnt + 1;
		index_hole_i <= (icnt < 8);
		read_pulse_i <= (icnt[3:0] == 4'h3);
		npulse <= npulse + (stepper_pulse_o === 1'b1);
		nflux <= nflux + (write_flux_o === 1'b1);
		iw_q <= line_oe_o[OUT_INDEX];
		nidx <= nidx + (line_oe_o[OUT_INDEX] === 1'b1 && iw_q === 1'b0);
	end
	// expected head track after one step
	function automatic int nxt(input int t, input logic out);
		return out ? ((t == 0) ? 0 : t - 1) : ((t == NUM_TRACKS - 1) ? t : t + 1);
	endfunction : nxt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, waiting for pready; only the watchdog ends a wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= dat;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask : apb
	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (60000) @(posedge mclk_i);
		num_errors++;
		test_done();
	end
	initial begin
		void'($urandom(32'he78c7fd8));
		// the unit address jumper is drawn at random
		ju = $urandom % 4;
		me = ~(4'h1 << ju);
		unit_address_jumpers_i <= 4'h1 << ju;
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		// control reset value, write back, unmapped address
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rdat, {29'h0, CTRL_RST});
		apb(1'b1, REG_CTRL, 32'h6);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rdat, 32'h6);
		apb(1'b1, REG_CTRL, {29'h0, CTRL_RST});
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		// only the jumpered unit answers, the others release the lines
		write_protect_sensor_i <= 1'b1;
		for (int u = 0; u < NUM_UNITS; u++) begin
			u_host.lv(~(4'h1 << u), 1'b1, 1'b1);
			apb(1'b0, REG_STATUS, 32'h0);
			chk({31'h0, rdat[0]}, (u == ju) ? 32'h1 : 32'h0);
			chk({27'h0, line_oe_o}, (u == ju) ? 32'h6 : 32'h0);
		end
		write_protect_sensor_i <= 1'b0;
		u_host.lv(me, 1'b1, 1'b1);
		// outward step at the outermost track, then random steps
		n0 = npulse;
		u_host.step(1'b1);
		chk(npulse, n0);
		for (int i = 0; i < 12; i++) begin
			d = ($urandom % 3) == 0;
			u_host.step(d);
			if (!(d && trk == 0)) begin
				n0++;
				lin = !d;
			end
			trk = nxt(trk, d);
			track0_sensor_i <= (trk == 0);
		end
		apb(1'b0, REG_STATUS, 32'h0);
		chk({25'h0, rdat[14:8]}, trk);
		chk(npulse, n0);
		chk({31'h0, stepper_inward_o}, {31'h0, lin});
		u_host.step(1'b0);
		trk = nxt(trk, 1'b0);
		track0_sensor_i <= 1'b0;
		while (trk > 1) begin
			u_host.step(1'b1);
			trk--;
		end
		// last step out: seek busy, outermost flag held back for its delay
		fork
			u_host.step(1'b1);
			begin
				@(posedge stepper_pulse_o);
				track0_sensor_i <= 1'b1;
				apb(1'b0, REG_STATUS, 32'h0);
				chk({31'h0, rdat[3]}, 32'h1);
				chk({31'h0, line_oe_o[OUT_TRK0]}, 32'h0);
				repeat (70) @(posedge mclk_i);
				chk({31'h0, line_oe_o[OUT_TRK0]}, 32'h1);
			end
		join
		// write bursts: enabled with a stray step, protected, unselected
		for (int k = 0; k < 3; k++) begin
			write_protect_sensor_i <= (k == 1);
			u_host.lv((k == 2) ? 4'hf : me, 1'b1, 1'b1);
			n0 = nflux;
			n1 = npulse;
			u_host.write(3, k == 0);
			chk(nflux - n0, (k == 0) ? 3 : 0);
			chk(npulse - n1, 0);
		end
		write_protect_sensor_i <= 1'b0;
		for (int s = 0; s < 2; s++) begin
			u_host.lv(me, 1'b1, s[0]);
			chk({31'h0, head_side_one_o}, {31'h0, !s[0]});
		end
		for (int j = 0; j < 4; j++) begin
			activity_input_jumper_i <= j[0];
			in_use_n_i <= j[1];
			repeat (8) @(posedge mclk_i);
			chk({31'h0, activity_o}, {31'h0, j[0] & !j[1]});
		end
		// spindle request without and with a disk: ready, index gating, drop on release
		for (int p = 0; p < 2; p++) begin
			disk_present_i <= p[0];
			u_host.lv(me, 1'b0, 1'b1);
			chk({31'h0, spindle_run_o}, 32'h1);
			repeat (3500) @(posedge mclk_i);
			apb(1'b0, REG_STATUS, 32'h0);
			chk({31'h0, rdat[1]}, p);
			chk({31'h0, line_oe_o[OUT_READY]}, p);
			apb(1'b0, REG_IDXPER, 32'h0);
			chk(rdat, 32'h3e8);
			n0 = nidx;
			repeat (2000) @(posedge mclk_i);
			chk(nidx - n0, 2 * p);
			u_host.lv(me, 1'b1, 1'b1);
			apb(1'b0, REG_STATUS, 32'h0);
			chk({31'h0, rdat[1]}, 32'h0);
		end
		test_done();
	end
endmodule : tb_top
`default_nettype wire
